//--- rtl/irq_seq_pkg.sv
// Constants and types shared by the CPU interrupt sequencer.
package irq_seq_pkg;
  // Register byte offsets.
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_NMI_IE = 5'h04;
  localparam logic [4:0] REG_FLAGS  = 5'h08;
  localparam logic [4:0] REG_PER_IE = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  // Control fields.
  localparam int CTRL_NMI_MODE = 0;
  localparam int CTRL_EDGE_SEL = 1;
  localparam int CTRL_OSC1_HF  = 2;
  localparam int CTRL_OSC2_ON  = 3;
  // Non-maskable enable and flag fields share positions.
  localparam int NMI_PIN   = 0;
  localparam int NMI_OSC   = 1;
  localparam int NMI_FLASH = 2;
  localparam int FLAG_WDT  = 3;
  localparam int FLAG_PRST = 4;
  localparam int GIE_BIT   = 3;
  localparam int N_MASK    = 30;
  // Reset values.
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [15:0] SR_RST   = 16'h0000;
  // Vectors, priorities and stack step.
  localparam logic [15:0] VEC_BASE   = 16'hFFC0;
  localparam logic [15:0] VEC_RESET  = 16'hFFFE;
  localparam logic [4:0]  PRIO_NMI   = 5'h1E;
  localparam logic [4:0]  PRIO_WDT   = 5'h1A;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  // Cycle counts of the two sequences.
  localparam int ACCEPT_CYCLES = 6;
  localparam int RETURN_CYCLES = 5;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_cmd_type;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_PUSH_PC, ST_PUSH_SR, ST_CLEAR,
    ST_VEC_ADDR, ST_VEC_LOAD, ST_RET_SR_ADDR, ST_RET_SR_LOAD,
    ST_RET_PC_ADDR, ST_RET_PC_LOAD
  } seq_state_type;
endpackage

//--- rtl/cpu_interrupt_sequencer.sv
// Interrupt acceptance, return and source logic of the CPU.
`timescale 1ns/1ps
// Function
// - Soft clear returns pin to reset function
// - Edge select change may raise NMI
// - Flash violation sets flag, gated request
// - Oscillator fault sets flag, gated request
// - Soft clear forces osc low, second off
// - NMI acceptance clears all three enables
// - Maskable sources gated individually and globally
// - Watchdog interval overflow is maskable source
// - Maskable needs both enables, NMI one
// - Acceptance to handler takes six cycles
// - Finish instruction, push PC, push status
// - Highest fixed priority pending is selected
// - Single-source flags clear, multi-source stay
// - Status word cleared after stacking
// - Program counter loaded from vector word
// - Return pops status then PC, five cycles
// - Global enable in handler allows preemption
// - Vectors occupy FFC0 to FFFF words
// - Reset FFFE, NMI FFFC, watchdog FFF4
// - Chosen pin edge sets flag, requests NMI
// - Low pin holds reset, rise restarts
module cpu_interrupt_sequencer
  import irq_seq_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [4:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              nmi_pin_i,
  input  wire logic              soft_power_up_clear_i,
  input  wire logic              osc_fault_i,
  input  wire logic              flash_violation_i,
  input  wire logic              wdt_interval_i,
  input  wire logic [N_MASK-1:0] irq_req_i,
  output logic      [N_MASK-1:0] irq_ack_o,
  input  wire logic              instr_boundary_i,
  input  wire logic              return_from_interrupt_i,
  input  wire logic [15:0]       pc_i,
  input  wire logic [15:0]       sp_i,
  input  wire logic              sr_we_i,
  input  wire logic [15:0]       sr_wdata_i,
  input  wire logic [15:0]       mem_rdata_i,
  output mem_cmd_type            mem_cmd_o,
  output logic      [15:0]       pc_o,
  output logic                   pc_load_o,
  output logic      [15:0]       sp_o,
  output logic                   sp_load_o,
  output logic      [15:0]       status_word_o,
  output logic                   cpu_hold_o,
  output logic                   cpu_reset_o,
  output logic                   first_osc_hf_o,
  output logic                   second_osc_on_o
);

  // ***********************************************
  // Helper functions
  // ***********************************************
  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  function automatic logic [4:0] top_prio(input logic [30:0] p);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 31; i++)
    begin
      if (p[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // ***********************************************
  // Declarations
  // ***********************************************
  seq_state_type     state_q;
  mem_cmd_type       cmd_q;
  logic              ack_q;
  logic [3:0]        ctrl_q;
  logic [2:0]        nmi_ie_q;
  logic [4:0]        flags_q;
  logic [N_MASK-1:0] per_ie_q;
  logic [N_MASK-1:0] ack_src_q;
  logic [15:0]       sr_q;
  logic [15:0]       sp_q;
  logic [15:0]       pc_q;
  logic              pc_load_q;
  logic              sp_load_q;
  logic [4:0]        prio_q;
  logic              pin_meta_q;
  logic              pin_lvl_q;
  logic              pin_prev_q;
  logic              act_prev_q;
  logic              cpu_reset_q;
  logic              wb_hit;
  logic              wb_wr;
  logic [31:0]       wb_mrg;
  logic [31:0]       wb_new;
  logic [31:0]       wb_clr;
  logic              nmi_act;
  logic              pin_nmi_evt;
  logic              pin_rst_evt;
  logic [N_MASK-1:0] mask_src;
  logic [N_MASK-1:0] mask_req;
  logic              nmi_req;
  logic [30:0]       pend;
  logic [4:0]        top;
  logic              accept_irq;
  logic              accept_ret;
  logic              nmi_sel;
  logic [15:0]       vec_addr;

  // ***********************************************
  // Wishbone slave
  // ***********************************************
  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr  = wb_hit & wb_we_i;
  assign wb_new = wmerge(wb_mrg, wb_dat_i, wb_sel_i);
  assign wb_clr = wmerge(32'h00000000, wb_dat_i, wb_sel_i);

  always_comb
  begin
    case (wb_adr_i)
      REG_CTRL:   wb_mrg = {28'h0000000, ctrl_q};
      REG_NMI_IE: wb_mrg = {29'h00000000, nmi_ie_q};
      REG_PER_IE: wb_mrg = {2'h0, per_ie_q};
      default:    wb_mrg = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      ack_q <= wb_hit;
      case (wb_adr_i)
        REG_CTRL:   wb_dat_o <= {28'h0000000, ctrl_q};
        REG_NMI_IE: wb_dat_o <= {29'h00000000, nmi_ie_q};
        REG_FLAGS:  wb_dat_o <= {27'h0000000, flags_q};
        REG_PER_IE: wb_dat_o <= {2'h0, per_ie_q};
        REG_STATUS:
          wb_dat_o <= {7'h00, cpu_hold_o, 3'h0, prio_q, sr_q};
        default:    wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;

  // ***********************************************
  // Pin synchroniser and pin events
  // ***********************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta_q  <= 1'b1;
      pin_lvl_q   <= 1'b1;
      pin_prev_q  <= 1'b1;
      act_prev_q  <= 1'b1;
      cpu_reset_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= nmi_pin_i;
      pin_lvl_q  <= pin_meta_q;
      pin_prev_q <= pin_lvl_q;
      act_prev_q <= nmi_act;
      cpu_reset_q <= (~ctrl_q[CTRL_NMI_MODE] & ~pin_lvl_q)
                     | soft_power_up_clear_i;
    end
  end

  // The active level folds the edge select in, so a select change
  // in NMI mode can itself look like an edge.
  // edge select toggling
  assign nmi_act = pin_lvl_q ^ ctrl_q[CTRL_EDGE_SEL];
  assign pin_nmi_evt = ctrl_q[CTRL_NMI_MODE] & nmi_act & ~act_prev_q;
  assign pin_rst_evt = ~ctrl_q[CTRL_NMI_MODE] & pin_lvl_q & ~pin_prev_q;

  // ***********************************************
  // Control and enable registers
  // ***********************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q   <= CTRL_RST;
      nmi_ie_q <= 3'h0;
      per_ie_q <= '0;
    end
    else
    begin
      if (soft_power_up_clear_i)
      begin
        ctrl_q[CTRL_NMI_MODE] <= 1'b0;
        ctrl_q[CTRL_OSC1_HF]  <= 1'b0;
        ctrl_q[CTRL_OSC2_ON]  <= 1'b0;
      end
      else if (wb_wr && wb_adr_i == REG_CTRL)
      begin
        ctrl_q <= wb_new[3:0];
      end
      if (accept_irq && nmi_sel)
      begin
        nmi_ie_q <= 3'h0;
      end
      else if (wb_wr && wb_adr_i == REG_NMI_IE)
      begin
        nmi_ie_q <= wb_new[2:0];
      end
      if (wb_wr && wb_adr_i == REG_PER_IE)
      begin
        per_ie_q <= wb_new[N_MASK-1:0];
      end
    end
  end

  assign first_osc_hf_o  = ctrl_q[CTRL_OSC1_HF];
  assign second_osc_on_o = ctrl_q[CTRL_OSC2_ON];

  // ***********************************************
  // Flags: hardware set wins over software clear
  // ***********************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flags_q <= 5'h00;
    end
    else
    begin
      if (wb_wr && wb_adr_i == REG_FLAGS)
      begin
        flags_q <= flags_q & ~wb_clr[4:0];
      end
      if (accept_irq && top == PRIO_WDT)
      begin
        flags_q[FLAG_WDT] <= 1'b0;
      end
      if (pin_nmi_evt)
      begin
        flags_q[NMI_PIN] <= 1'b1;
      end
      if (osc_fault_i)
      begin
        flags_q[NMI_OSC] <= 1'b1;
      end
      if (flash_violation_i)
      begin
        flags_q[NMI_FLASH] <= 1'b1;
      end
      if (wdt_interval_i)
      begin
        flags_q[FLAG_WDT] <= 1'b1;
      end
      if (pin_rst_evt)
      begin
        flags_q[FLAG_PRST] <= 1'b1;
      end
    end
  end

  // ***********************************************
  // Request gating and priority
  // ***********************************************
  // watchdog at priority 26
  always_comb
  begin
    mask_src = irq_req_i;
    mask_src[PRIO_WDT] = flags_q[FLAG_WDT];
  end

  assign mask_req = mask_src & per_ie_q & {N_MASK{sr_q[GIE_BIT]}};
  assign nmi_req  = |(flags_q[2:0] & nmi_ie_q);
  assign pend     = {nmi_req, mask_req};
  assign top      = top_prio(pend);
  assign nmi_sel  = (top == PRIO_NMI);
  assign accept_irq = (state_q == ST_IDLE) & instr_boundary_i & (|pend);
  assign accept_ret = (state_q == ST_IDLE) & instr_boundary_i & return_from_interrupt_i
                      & ~(|pend);
  assign vec_addr = VEC_BASE | {10'h000, prio_q, 1'b0};

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_src_q <= '0;
    end
    else
    begin
      ack_src_q <= '0;
      if (accept_irq && !nmi_sel)
      begin
        ack_src_q[top] <= 1'b1;
      end
    end
  end

  assign irq_ack_o = ack_src_q;

  // ***********************************************
  // Status word
  // ***********************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sr_q <= SR_RST;
    end
    else if (cpu_reset_q)
    begin
      sr_q <= SR_RST;
    end
    else if (state_q == ST_PUSH_SR)
    begin
      sr_q <= SR_RST;
    end
    else if (state_q == ST_RET_SR_LOAD)
    begin
      sr_q <= mem_rdata_i;
    end
    else if (sr_we_i)
    begin
      sr_q <= sr_wdata_i;
    end
  end

  assign status_word_o = sr_q;

  // ***********************************************
  // Acceptance and return sequencer
  // ***********************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q   <= ST_RESET;
      cmd_q     <= '0;
      sp_q      <= 16'h0000;
      pc_q      <= 16'h0000;
      pc_load_q <= 1'b0;
      sp_load_q <= 1'b0;
      prio_q    <= 5'h00;
    end
    else
    begin
      cmd_q     <= '0;
      pc_load_q <= 1'b0;
      sp_load_q <= 1'b0;
      if (cpu_reset_q)
      begin
        state_q <= ST_RESET;
      end
      else
      begin
        case (state_q)
          ST_RESET:
          begin
            state_q <= ST_VEC_ADDR;
            cmd_q   <= '{1'b0, 1'b1, VEC_RESET, 16'h0000};
          end
          ST_IDLE:
          begin
            if (accept_irq)
            begin
              state_q <= ST_PUSH_PC;
              cmd_q   <= '{1'b1, 1'b0, sp_i - STACK_STEP, pc_i};
              sp_q    <= sp_i - STACK_STEP - STACK_STEP;
              prio_q  <= top;
            end
            else if (accept_ret)
            begin
              state_q <= ST_RET_SR_ADDR;
              cmd_q   <= '{1'b0, 1'b1, sp_i, 16'h0000};
              sp_q    <= sp_i + STACK_STEP + STACK_STEP;
            end
          end
          ST_PUSH_PC:
          begin
            state_q <= ST_PUSH_SR;
            cmd_q   <= '{1'b1, 1'b0, sp_q, sr_q};
          end
          ST_PUSH_SR:
          begin
            state_q   <= ST_CLEAR;
            sp_load_q <= 1'b1;
          end
          ST_CLEAR:
          begin
            state_q <= ST_VEC_ADDR;
            cmd_q   <= '{1'b0, 1'b1, vec_addr, 16'h0000};
          end
          ST_VEC_ADDR:
          begin
            state_q <= ST_VEC_LOAD;
          end
          ST_VEC_LOAD:
          begin
            state_q   <= ST_IDLE;
            pc_q      <= mem_rdata_i;
            pc_load_q <= 1'b1;
          end
          ST_RET_SR_ADDR:
          begin
            state_q <= ST_RET_SR_LOAD;
          end
          ST_RET_SR_LOAD:
          begin
            state_q <= ST_RET_PC_ADDR;
            cmd_q   <= '{1'b0, 1'b1, sp_q - STACK_STEP, 16'h0000};
          end
          ST_RET_PC_ADDR:
          begin
            state_q <= ST_RET_PC_LOAD;
          end
          ST_RET_PC_LOAD:
          begin
            state_q   <= ST_IDLE;
            pc_q      <= mem_rdata_i;
            pc_load_q <= 1'b1;
            sp_load_q <= 1'b1;
          end
          default:
          begin
            state_q <= ST_RESET;
          end
        endcase
      end
    end
  end

  assign mem_cmd_o   = cmd_q;
  assign pc_o        = pc_q;
  assign pc_load_o   = pc_load_q;
  assign sp_o        = sp_q;
  assign sp_load_o   = sp_load_q;
  assign cpu_hold_o  = (state_q != ST_IDLE);
  assign cpu_reset_o = cpu_reset_q;

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_puc_pin_osc: assert property (
    soft_power_up_clear_i |=> !ctrl_q[CTRL_NMI_MODE]
      && !first_osc_hf_o && !second_osc_on_o)
    else $error("Soft clear left pin mode or oscillators set.");

  chk_flash_flag_set: assert property (
    flash_violation_i |=> flags_q[NMI_FLASH])
    else $error("Flash violation flag not set.");

  chk_nmi_ie_clear: assert property (
    accept_irq && nmi_sel |=> nmi_ie_q == 3'h0)
    else $error("NMI enables survived acceptance.");

  chk_mask_gate_ok: assert property (
    accept_irq && !nmi_sel |-> sr_q[GIE_BIT] && per_ie_q[top])
    else $error("Masked source was accepted.");

  chk_latency_six: assert property (
    accept_irq |=> cpu_hold_o [*5] ##1 (pc_load_o && !cpu_hold_o))
    else $error("Acceptance did not take six cycles.");

  chk_push_order: assert property (
    accept_irq |=> (mem_cmd_o.we && mem_cmd_o.wdata == $past(pc_i))
      ##1 (mem_cmd_o.we && mem_cmd_o.wdata == $past(sr_q, 2)))
    else $error("PC and status word not stacked in order.");

  chk_sr_cleared: assert property (
    accept_irq |-> ##3 sr_q == SR_RST)
    else $error("Status word not cleared after stacking.");

  chk_vec_fetch: assert property (
    accept_irq |-> ##4 mem_cmd_o.re
      && mem_cmd_o.addr == (VEC_BASE | {10'h000, $past(top, 4), 1'b0}))
    else $error("Wrong vector word fetched.");

  chk_return_from_interrupt_five: assert property (
    accept_ret |-> ##5 pc_load_o && sp_load_o
      && sp_o == $past(sp_i, 5) + 16'h0004)
    else $error("Return did not complete in five cycles.");

  chk_sp_predec: assert property (
    accept_irq |-> ##3 sp_load_o && sp_o == $past(sp_i, 3) - 16'h0004)
    else $error("Stack pointer not lowered by two words.");

endmodule

//--- bench/core_mem_model.sv
// Memory and stack model that stands on the core side of the sequencer.
`timescale 1ns/1ps
module core_mem_model
  import irq_seq_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire mem_cmd_type mem_cmd_i,
  output logic      [15:0] mem_rdata_o
);
  // ****************************************
  // Byte-addressed word store
  // ****************************************
  logic [15:0] mem [0:65535];

  // Every word starts as its address XOR 5A5A, so the vectors are known.
  initial
  begin
    for (int a = 0; a < 65536; a++)
      mem[a] = 16'(a) ^ 16'h5A5A;
  end

  // Read data lasts one cycle; otherwise the bus toggles so stale data never matches.
  always @(posedge clk_sys_i)
  begin
    if (mem_cmd_i.we)
      mem[mem_cmd_i.addr] <= mem_cmd_i.wdata;
    if (mem_cmd_i.re)
      mem_rdata_o <= mem[mem_cmd_i.addr];
    else
      mem_rdata_o <= ~mem_rdata_o;
  end
endmodule

//--- bench/tb.sv
// Self-checking bench for the CPU interrupt sequencer.
`timescale 1ns/1ps
module tb;
  import irq_seq_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic              clk_sys_i = 1'b0;
  logic              rst_n_i   = 1'b0;
  logic              cyc = 0, stb = 0, we = 0;
  logic [4:0]        adr = '0;
  logic [3:0]        sel = '0;
  logic [31:0]       wdat = '0, rdat, wb_dat_o;
  logic              wb_ack_o, pc_load_o, sp_load_o, cpu_hold_o, cpu_reset_o, hf_o, on_o;
  logic              pin = 1, spuc = 0, oscf = 0, flash = 0, wdt = 0;
  logic              bnd = 0, return_from_interrupt = 0, sr_we = 0;
  logic [N_MASK-1:0] req = '0, irq_ack_o, ack;
  logic [15:0]       pc = '0, sp = '0, sr_wd = '0, rdata, pc_o, sp_o, status_word_o;
  mem_cmd_type       mem_cmd_o;
  int                n_fail = 0, n_compared = 0, n;

  always #4 clk_sys_i = ~clk_sys_i;

  cpu_interrupt_sequencer uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_pin_i(pin), .soft_power_up_clear_i(spuc),
    .osc_fault_i(oscf), .flash_violation_i(flash), .wdt_interval_i(wdt), .irq_req_i(req),
    .irq_ack_o(irq_ack_o), .instr_boundary_i(bnd), .return_from_interrupt_i(return_from_interrupt), .pc_i(pc), .sp_i(sp),
    .sr_we_i(sr_we), .sr_wdata_i(sr_wd), .mem_rdata_i(rdata), .mem_cmd_o(mem_cmd_o),
    .pc_o(pc_o), .pc_load_o(pc_load_o), .sp_o(sp_o), .sp_load_o(sp_load_o),
    .status_word_o(status_word_o), .cpu_hold_o(cpu_hold_o), .cpu_reset_o(cpu_reset_o),
    .first_osc_hf_o(hf_o), .second_osc_on_o(on_o));

  core_mem_model mdl (.clk_sys_i(clk_sys_i), .mem_cmd_i(mem_cmd_o), .mem_rdata_o(rdata));

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [15:0] vec(input logic [15:0] a);
    return a ^ 16'h5A5A;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Enables and flags are only ever touched one byte lane at a time.
  // byte lanes only
  task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    @(posedge clk_sys_i);
    while (wb_ack_o !== 1'b1 && t < 50)
    begin
      @(posedge clk_sys_i);
      t++;
    end
    rdat = wb_dat_o;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
    if (t >= 50)
      chk("wb_ack_o", 0, 1);
  endtask

  task automatic wait_load(output int k);
    k = 1;
    #1;
    while (pc_load_o !== 1'b1 && k < 40)
    begin
      @(posedge clk_sys_i);
      k++;
      #1;
    end
  endtask

  task automatic boundary(input logic r, input logic [15:0] p, input logic [15:0] s);
    @(posedge clk_sys_i);
    bnd  <= 1'b1;
    return_from_interrupt <= r;
    pc   <= p;
    sp   <= s;
    @(posedge clk_sys_i);
    bnd  <= 1'b0;
    return_from_interrupt <= 1'b0;
  endtask

  task automatic no_take;
    boundary(1'b0, 16'h2000, 16'h0300);
    #1 chk("cpu_hold_o", cpu_hold_o, 0);
  endtask

  task automatic set_sr(input logic [15:0] v);
    @(posedge clk_sys_i);
    sr_we <= 1'b1;
    sr_wd <= v;
    @(posedge clk_sys_i);
    sr_we <= 1'b0;
  endtask

  task automatic accept(input logic [15:0] p, s, v, srx);
    boundary(1'b0, p, s);
    #1 ack = irq_ack_o;
    wait_load(n);
    chk("accept cycles", n, ACCEPT_CYCLES);
    chk("pc_o", pc_o, vec(v));
    chk("stacked pc", mdl.mem[s - 16'h0002], p);
    chk("stacked sr", mdl.mem[s - 16'h0004], srx);
    chk("status_word_o", status_word_o, 0);
    chk("sp_o", sp_o, s - 16'h0004);
  endtask

  task automatic ret(input logic [15:0] s, p, srx);
    boundary(1'b1, 16'h0000, s);
    wait_load(n);
    chk("return cycles", n, RETURN_CYCLES);
    chk("pc_o", pc_o, p);
    chk("status_word_o", status_word_o, srx);
    chk("sp_o", sp_o, s + 16'h0004);
  endtask

  task automatic pulse_src(input int i);
    @(posedge clk_sys_i);
    if (i == 0)
      flash <= 1'b1;
    else if (i == 1)
      oscf <= 1'b1;
    else
      pin <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    flash <= 1'b0;
    oscf  <= 1'b0;
    pin   <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_mask;
    wb(1'b1, REG_PER_IE, 4'h1, 32'h20);
    @(posedge clk_sys_i);
    req <= 30'h20;
    no_take;
    set_sr(16'h0008);
    accept(16'h1234, 16'h0400, VEC_BASE + 16'h000A, 16'h0008);
    chk("irq_ack_o", ack, 30'h20);
    @(posedge clk_sys_i) req <= '0;
    ret(16'h03FC, 16'h1234, 16'h0008);
    wb(1'b1, REG_PER_IE, 4'h1, 32'h0);
    req <= 30'h20;
    no_take;
    @(posedge clk_sys_i) req <= '0;
    $display("end of mask test");
  endtask

  task automatic t_prio;
    wb(1'b1, REG_PER_IE, 4'h1, 32'h08);
    wb(1'b1, REG_PER_IE, 4'h8, 32'h0400_0000);
    @(posedge clk_sys_i);
    wdt <= 1'b1;
    req <= 30'h08;
    @(posedge clk_sys_i);
    wdt <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    accept(16'h2222, 16'h0400, 16'hFFF4, 16'h0008);
    wb(1'b0, REG_FLAGS, 4'h1, 32'h0);
    chk("watchdog flag", rdat[FLAG_WDT], 0);
    wb(1'b0, REG_STATUS, 4'hF, 32'h0);
    chk("served priority", rdat[20:16], 5'h1A);
    set_sr(16'h0008);
    accept(16'h3333, 16'h03FC, VEC_BASE + 16'h0006, 16'h0008);
    @(posedge clk_sys_i) req <= '0;
    $display("end of priority test");
  endtask

  task automatic t_nmi;
    wb(1'b1, REG_CTRL, 4'h1, 32'h0D);
    // Toggling the edge select in NMI mode with the pin high makes an edge.
    wb(1'b1, REG_CTRL, 4'h1, 32'h0F);
    wb(1'b1, REG_CTRL, 4'h1, 32'h0D);
    wb(1'b0, REG_FLAGS, 4'h1, 32'h0);
    chk("pin flag on select", rdat[NMI_PIN], 1);
    wb(1'b1, REG_FLAGS, 4'h1, 32'h1F);
    // No return is run between passes; each pass re-enables only its own source.
    // re-enable own source only
    for (int i = 0; i < 3; i++)
    begin
      pulse_src(i);
      no_take;
      wb(1'b0, REG_FLAGS, 4'h1, 32'h0);
      chk("nmi flag", rdat[2 - i], 1);
      wb(1'b1, REG_NMI_IE, 4'h1, 32'h1 << (2 - i));
      accept(16'h4444, 16'h0500, 16'hFFFC, 16'h0000);
      chk("irq_ack_o", ack, 0);
      wb(1'b0, REG_NMI_IE, 4'h1, 32'h0);
      chk("nmi enables", rdat[2:0], 0);
      wb(1'b0, REG_FLAGS, 4'h1, 32'h0);
      chk("nmi flag kept", rdat[2 - i], 1);
      wb(1'b1, REG_FLAGS, 4'h1, 32'h1F);
    end
    $display("end of nmi test");
  endtask

  task automatic t_clear;
    chk("first_osc_hf_o", hf_o, 1);
    @(posedge clk_sys_i);
    pin  <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    spuc <= 1'b1;
    @(posedge clk_sys_i);
    spuc <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk("cpu_reset_o", cpu_reset_o, 1);
    chk("first_osc_hf_o", hf_o, 0);
    chk("second_osc_on_o", on_o, 0);
    pin <= 1'b1;
    wait_load(n);
    chk("pc_o", pc_o, vec(VEC_RESET));
    wb(1'b0, REG_FLAGS, 4'h1, 32'h0);
    chk("pin reset flag", rdat[FLAG_PRST], 1);
    $display("end of clear test");
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wait_load(n);
    chk("pc_o", pc_o, vec(VEC_RESET));
    chk("cpu_reset_o", cpu_reset_o, 0);
    $display("end of reset test");
    repeat (3) @(posedge clk_sys_i);
    t_mask;
    t_prio;
    t_nmi;
    t_clear;
    test_done;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    test_done;
  end
endmodule
